/* File: rtl/dsos_top.sv */
`timescale 1ns/1ns
`default_nettype none
module dsos_top #(
  parameter int unsigned TICK_CYCLES = dsos_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Drive conditions
  input wire dsos_pkg::dsos_cond_s cond,
  input wire logic [dsos_pkg::ANA_W-1:0] analog_value,
  // Configuration load
  input wire logic cfg_load,
  input wire dsos_pkg::dsos_cfg_s cfg_in,
  // Outputs to terminal and relays
  output logic transistor_output_terminal,
  output logic relay3_output,
  output logic relay4_output,
  // Status
  output logic fault_output_state,
  output var dsos_pkg::dsos_cfg_s cfg_active
);

  localparam int unsigned DIV_W = $clog2(TICK_CYCLES + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

  typedef struct packed {
    dsos_pkg::dsos_cfg_s cfg;
    logic [DIV_W-1:0] div;
    logic tick;
    logic ana_on;
    logic term;
    logic relay3;
    logic relay4;
    logic fault;
  } dsos_top_state_s;

  dsos_top_state_s s;
  dsos_top_state_s next_s;
  logic trip_qualified;
  logic trip_delayed;
  logic timer_done;

  // Limit a delay to its legal top
  function automatic logic [dsos_pkg::DLY_W-1:0] clamp_dly(
    input logic [dsos_pkg::DLY_W-1:0] d
  );
    clamp_dly = (d > dsos_pkg::DLY_MAX) ? dsos_pkg::DLY_MAX : d;
  endfunction : clamp_dly

  // Map a function code onto its condition
  function automatic logic select_fn(
    input logic [dsos_pkg::SEL_W-1:0] code,
    input dsos_pkg::dsos_cond_s c,
    input logic ana_on,
    input logic trip_out,
    input logic timer_out
  );
    logic running;
    running = c.run_cmd && c.output_voltage && !c.dc_braking;
    case (code)
      dsos_pkg::FN_LOW_VOLTAGE: select_fn = c.dc_undervoltage;
      dsos_pkg::FN_OVER_HEAT: select_fn = c.over_temperature;
      dsos_pkg::FN_LOST_CMD: begin
        select_fn = c.analog_ref_lost || c.serial_cmd_lost ||
                    (c.exp_card_present && c.exp_cmd_lost);
      end
      dsos_pkg::FN_RUN: select_fn = running;
      dsos_pkg::FN_STOP: select_fn = !c.run_cmd && !c.output_voltage;
      dsos_pkg::FN_STEADY: begin
        select_fn = running && !c.accelerating && !c.decelerating;
      end
      dsos_pkg::FN_DRIVE_LINE: select_fn = c.motor_on_drive_line;
      dsos_pkg::FN_MAINS_LINE: select_fn = c.motor_on_mains;
      dsos_pkg::FN_SPEED_SEARCH: select_fn = c.speed_search;
      dsos_pkg::FN_READY: select_fn = c.standby_ready;
      dsos_pkg::FN_TIMER: select_fn = timer_out;
      dsos_pkg::FN_TRIP: select_fn = trip_out;
      dsos_pkg::FN_BRAKE_DUTY: select_fn = c.brake_resistor_duty_warning;
      dsos_pkg::FN_ANALOG_ONOFF: select_fn = ana_on;
      dsos_pkg::FN_BRAKE_RELEASE: select_fn = c.brake_release_output;
      default: select_fn = 1'b0;
    endcase
  endfunction : select_fn

  // Trip classes gated by the mask
  assign trip_qualified =
    (s.cfg.trip_mask[dsos_pkg::MASK_UV] && cond.trip_undervoltage) ||
    (s.cfg.trip_mask[dsos_pkg::MASK_OTHER] && cond.trip_other) ||
    (s.cfg.trip_mask[dsos_pkg::MASK_RESTART] && cond.restart_failed);

  // Trip output delay; general output delays are not applied in trip mode
  dsos_delay u_trip_delay (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tick(s.tick),
    .level_in(trip_qualified),
    .on_delay(s.cfg.fault_output_assert_delay),
    .off_delay(s.cfg.fault_output_release_delay),
    .level_out(trip_delayed)
  );

  // Timer output: on after the set time while the input holds
  dsos_delay u_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tick(s.tick),
    .level_in(cond.timer_input),
    .on_delay(s.cfg.timer_delay),
    .off_delay(dsos_pkg::DLY_RESET),
    .level_out(timer_done)
  );

  // Next state: divider, config capture, hysteresis and output select
  always_comb begin
    next_s = s;
    // Delay unit divider, one pulse per unit
    if (s.div == DIV_LAST) begin
      next_s.div = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.div = s.div + DIV_W'(1);
      next_s.tick = 1'b0;
    end
    // Capture settings; delays above the top are clamped
    if (cfg_load) begin
      next_s.cfg = cfg_in;
      next_s.cfg.fault_output_assert_delay = clamp_dly(cfg_in.fault_output_assert_delay);
      next_s.cfg.fault_output_release_delay = clamp_dly(cfg_in.fault_output_release_delay);
      next_s.cfg.timer_delay = clamp_dly(cfg_in.timer_delay);
    end
    // Hysteresis stops chatter when the value sits between the levels
    if (analog_value >= s.cfg.ana_on_level) begin
      next_s.ana_on = 1'b1;
    end else if (analog_value <= s.cfg.ana_off_level) begin
      next_s.ana_on = 1'b0;
    end
    // Terminal and both relays pick their own function; fault follows the trip
    next_s.term = select_fn(s.cfg.term_sel, cond, s.ana_on, trip_delayed, timer_done);
    next_s.relay3 = select_fn(s.cfg.relay3_sel, cond, s.ana_on, trip_delayed, timer_done);
    next_s.relay4 = select_fn(s.cfg.relay4_sel, cond, s.ana_on, trip_delayed, timer_done);
    next_s.fault = trip_delayed;
  end

  // State register with documented defaults
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s.cfg.term_sel <= dsos_pkg::TERM_SEL_RESET;
      s.cfg.relay3_sel <= dsos_pkg::RELAY_SEL_RESET;
      s.cfg.relay4_sel <= dsos_pkg::RELAY_SEL_RESET;
      s.cfg.trip_mask <= dsos_pkg::MASK_RESET;
      s.cfg.fault_output_assert_delay <= dsos_pkg::DLY_RESET;
      s.cfg.fault_output_release_delay <= dsos_pkg::DLY_RESET;
      s.cfg.timer_delay <= dsos_pkg::DLY_RESET;
      s.cfg.ana_on_level <= dsos_pkg::ANA_ON_RESET;
      s.cfg.ana_off_level <= dsos_pkg::ANA_OFF_RESET;
      s.div <= '0;
      s.tick <= 1'b0;
      s.ana_on <= 1'b0;
      s.term <= 1'b0;
      s.relay3 <= 1'b0;
      s.relay4 <= 1'b0;
      s.fault <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // Ports straight from the state flops
  assign transistor_output_terminal = s.term;
  assign relay3_output = s.relay3;
  assign relay4_output = s.relay4;
  assign fault_output_state = s.fault;
  assign cfg_active = s.cfg;

endmodule : dsos_top
`default_nettype wire

/* File: inc/dsos_pkg.sv */
// Shared constants and carriers for the drive status output selector
package dsos_pkg;

  // Function selector codes
  localparam int unsigned SEL_W = 6;
  localparam logic [SEL_W-1:0] FN_LOW_VOLTAGE = 6'h0B;
  localparam logic [SEL_W-1:0] FN_OVER_HEAT = 6'h0C;
  localparam logic [SEL_W-1:0] FN_LOST_CMD = 6'h0D;
  localparam logic [SEL_W-1:0] FN_RUN = 6'h0E;
  localparam logic [SEL_W-1:0] FN_STOP = 6'h0F;
  localparam logic [SEL_W-1:0] FN_STEADY = 6'h10;
  localparam logic [SEL_W-1:0] FN_DRIVE_LINE = 6'h11;
  localparam logic [SEL_W-1:0] FN_MAINS_LINE = 6'h12;
  localparam logic [SEL_W-1:0] FN_SPEED_SEARCH = 6'h13;
  localparam logic [SEL_W-1:0] FN_READY = 6'h16;
  localparam logic [SEL_W-1:0] FN_TIMER = 6'h1C;
  localparam logic [SEL_W-1:0] FN_TRIP = 6'h1D;
  localparam logic [SEL_W-1:0] FN_BRAKE_DUTY = 6'h1F;
  localparam logic [SEL_W-1:0] FN_ANALOG_ONOFF = 6'h22;
  localparam logic [SEL_W-1:0] FN_BRAKE_RELEASE = 6'h23;

  // Trip class mask: bit1..bit3 sit at indices 0..2
  localparam int unsigned MASK_W = 3;
  localparam int unsigned MASK_UV = 0;
  localparam int unsigned MASK_OTHER = 1;
  localparam int unsigned MASK_RESTART = 2;
  localparam logic [MASK_W-1:0] MASK_RESET = 3'h2;
  localparam logic [SEL_W-1:0] RELAY_SEL_RESET = FN_TRIP;
  localparam logic [SEL_W-1:0] TERM_SEL_RESET = 6'h00;

  // Delays count in hundredths of a second, 0.00 to 100.00 s
  localparam int unsigned DLY_W = 14;
  localparam logic [DLY_W-1:0] DLY_MAX = 14'h2710;
  localparam logic [DLY_W-1:0] DLY_RESET = 14'h0000;
  localparam longint unsigned DLY_UNIT_NS = 10_000_000;
  localparam longint unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned TICK_CYCLES = int'(DLY_UNIT_NS / CLK_PERIOD_NS);

  // Analog input width for on/off control
  localparam int unsigned ANA_W = 12;
  localparam logic [ANA_W-1:0] ANA_ON_RESET = 12'hFFF;
  localparam logic [ANA_W-1:0] ANA_OFF_RESET = 12'h000;

  // Conditions from protection and sequencing logic
  typedef struct packed {
    logic dc_undervoltage;
    logic over_temperature;
    logic analog_ref_lost;
    logic serial_cmd_lost;
    logic exp_card_present;
    logic exp_cmd_lost;
    logic run_cmd;
    logic output_voltage;
    logic dc_braking;
    logic accelerating;
    logic decelerating;
    logic motor_on_drive_line;
    logic motor_on_mains;
    logic speed_search;
    logic standby_ready;
    logic timer_input;
    logic trip_undervoltage;
    logic trip_other;
    logic restart_failed;
    logic brake_resistor_duty_warning;
    logic brake_release_output;
  } dsos_cond_s;

  // Configuration set, captured on a load strobe
  typedef struct packed {
    logic [SEL_W-1:0] term_sel;
    logic [SEL_W-1:0] relay3_sel;
    logic [SEL_W-1:0] relay4_sel;
    logic [MASK_W-1:0] trip_mask;
    logic [DLY_W-1:0] fault_output_assert_delay;
    logic [DLY_W-1:0] fault_output_release_delay;
    logic [DLY_W-1:0] timer_delay;
    logic [ANA_W-1:0] ana_on_level;
    logic [ANA_W-1:0] ana_off_level;
  } dsos_cfg_s;

  // Delay stage states
  typedef enum logic [3:0] {
    DST_OFF = 4'h1,
    DST_ON_WAIT = 4'h2,
    DST_ON = 4'h4,
    DST_OFF_WAIT = 4'h8
  } dsos_dst_e;

endpackage : dsos_pkg

/* File: rtl/dsos_delay.sv */
`timescale 1ns/1ns
`default_nettype none
// On/off delay of a level, counted in ticks of the delay unit
module dsos_delay (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Delay unit pulse
  input wire logic tick,
  // Level and delays
  input wire logic level_in,
  input wire logic [dsos_pkg::DLY_W-1:0] on_delay,
  input wire logic [dsos_pkg::DLY_W-1:0] off_delay,
  output logic level_out
);

  typedef struct packed {
    dsos_pkg::dsos_dst_e st;
    logic [dsos_pkg::DLY_W-1:0] cnt;
  } dsos_delay_state_s;

  dsos_delay_state_s s;
  dsos_delay_state_s next_s;
  logic [dsos_pkg::DLY_W-1:0] cnt_inc;

  // Output holds through the off wait
  assign level_out = (s.st == dsos_pkg::DST_ON) || (s.st == dsos_pkg::DST_OFF_WAIT);
  assign cnt_inc = s.cnt + 14'h0001;

  // Sequencing; a lost level restarts the wait, no partial credit
  always_comb begin
    next_s = s;
    case (s.st)
      dsos_pkg::DST_OFF: begin
        next_s.cnt = '0;
        if (level_in) begin
          next_s.st = (on_delay == '0) ? dsos_pkg::DST_ON : dsos_pkg::DST_ON_WAIT;
        end
      end
      dsos_pkg::DST_ON_WAIT: begin
        if (!level_in) begin
          next_s.st = dsos_pkg::DST_OFF;
        end else if (tick) begin
          next_s.cnt = cnt_inc;
          if (cnt_inc >= on_delay) begin
            next_s.st = dsos_pkg::DST_ON;
          end
        end
      end
      dsos_pkg::DST_ON: begin
        next_s.cnt = '0;
        if (!level_in) begin
          next_s.st = (off_delay == '0) ? dsos_pkg::DST_OFF : dsos_pkg::DST_OFF_WAIT;
        end
      end
      dsos_pkg::DST_OFF_WAIT: begin
        if (level_in) begin
          next_s.st = dsos_pkg::DST_ON;
          next_s.cnt = '0;
        end else if (tick) begin
          next_s.cnt = cnt_inc;
          if (cnt_inc >= off_delay) begin
            next_s.st = dsos_pkg::DST_OFF;
          end
        end
      end
      default: begin
        next_s.st = dsos_pkg::DST_OFF;
        next_s.cnt = '0;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s.st <= dsos_pkg::DST_OFF;
      s.cnt <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : dsos_delay
`default_nettype wire

/* File: verification/dsos_props.sv */
`timescale 1ns/1ns
`default_nettype none
// Port-level checks of the status output selector
module dsos_props #(
  parameter int unsigned TICK_CYCLES = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Inputs
  input wire dsos_pkg::dsos_cond_s cond,
  input wire logic [dsos_pkg::ANA_W-1:0] analog_value,
  input wire logic cfg_load,
  input wire dsos_pkg::dsos_cfg_s cfg_in,
  // Outputs
  input wire logic transistor_output_terminal,
  input wire logic relay3_output,
  input wire logic relay4_output,
  input wire logic fault_output_state,
  input wire dsos_pkg::dsos_cfg_s cfg_active
);
  logic qual;
  logic [dsos_pkg::SEL_W-1:0] s3;

  // Trip qualified through the class mask
  assign s3 = cfg_active.relay3_sel;
  assign qual = (cfg_active.trip_mask[0] & cond.trip_undervoltage) |
                (cfg_active.trip_mask[1] & cond.trip_other) |
                (cfg_active.trip_mask[2] & cond.restart_failed);

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Zero-delay trip: seen, stage, then output
  sequence trip_seen;
    qual && cfg_active.fault_output_assert_delay == 14'h0000 && !cfg_load;
  endsequence
  sequence out_up;
    ##2 fault_output_state;
  endsequence

  mask_load_a: assert property (cfg_load |=> cfg_active.trip_mask == $past(cfg_in.trip_mask))
    else $error("trip mask not loaded");
  low_volt_a: assert property (s3 == 6'h0B && cond.dc_undervoltage |=> relay3_output)
    else $error("low voltage output missing");
  run_brake_a: assert property (s3 == 6'h0E && cond.dc_braking |=> !relay3_output)
    else $error("run output during braking");
  stop_out_a: assert property (s3 == 6'h0F && !cond.run_cmd &&
    !cond.output_voltage |=> relay3_output)
    else $error("stop output missing");
  undef_sel_a: assert property (cfg_active.term_sel == 6'h00 |=> !transistor_output_terminal)
    else $error("undefined code drives terminal");
  trip_zero_a: assert property (trip_seen |-> out_up)
    else $error("trip output late");
  trip_relay_a: assert property (s3 == 6'h1D |=> relay3_output == fault_output_state)
    else $error("relay does not follow trip");
  trip_cause_a: assert property ($rose(fault_output_state) |-> $past(qual, 2))
    else $error("trip output without cause");
endmodule : dsos_props
`default_nettype wire

/* File: verification/dsos_load_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Relay coils and controller inputs sensing the outputs
module dsos_load_model (
  // Driven outputs
  input wire logic term,
  input wire logic relay3,
  input wire logic relay4,
  // Contacts as the controller reads them
  output logic [2:0] seen
);
  // Coils pull in on a high drive; bounce not modelled
  assign seen = {term, relay3, relay4};
endmodule : dsos_load_model
`default_nettype wire

/* File: verification/test_drive_status_output_select.sv */
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench for the status output selector
module test_drive_status_output_select;
  localparam int unsigned TK = 4;
  localparam logic [5:0] CODES [16] = '{6'h00, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h10,
    6'h11, 6'h12, 6'h13, 6'h16, 6'h1D, 6'h1F, 6'h23, 6'h14, 6'h3F};
  localparam logic [11:0] AV [6] = '{12'h900, 12'h600, 12'h300, 12'h600, 12'h800, 12'h400};
  localparam logic [5:0] AE = 6'b110010;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  dsos_pkg::dsos_cond_s cond = '0;
  dsos_pkg::dsos_cond_s tv;
  logic [11:0] analog_value = 12'h000;
  logic cfg_load = 1'b0;
  dsos_pkg::dsos_cfg_s cfg_in = '0;
  dsos_pkg::dsos_cfg_s cfg_active;
  dsos_pkg::dsos_cfg_s cf;
  logic q_out, r3_out, r4_out, fos;
  logic [2:0] seen;
  int fail_count = 0;
  int comparisons = 0;

  // Clock
  always #2 core_clk = ~core_clk;

  dsos_top #(.TICK_CYCLES(TK)) dsos_top_i (.core_clk(core_clk), .rst_n(rst_n), .cond(cond),
    .analog_value(analog_value), .cfg_load(cfg_load), .cfg_in(cfg_in),
    .transistor_output_terminal(q_out), .relay3_output(r3_out), .relay4_output(r4_out),
    .fault_output_state(fos), .cfg_active(cfg_active));
  dsos_load_model dsos_load_model_i (.term(q_out), .relay3(r3_out), .relay4(r4_out), .seen(seen));

  task automatic chk(input string nm, input logic [86:0] exp, input logic [86:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask : chk

  task automatic give_verdict();
    if (fail_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  // Sample just after the edge so its updates have landed
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wt

  task automatic load(input dsos_pkg::dsos_cfg_s c);
    @(posedge core_clk);
    cfg_in <= c;
    cfg_load <= 1'b1;
    @(posedge core_clk);
    cfg_load <= 1'b0;
  endtask : load

  task automatic put(input dsos_pkg::dsos_cond_s v);
    @(posedge core_clk);
    cond <= v;
  endtask : put

  // One-hot conditions, then run combinations
  function automatic dsos_pkg::dsos_cond_s vec(input int j);
    dsos_pkg::dsos_cond_s v;
    v = (j < 21) ? dsos_pkg::dsos_cond_s'(21'h1 << j) : '0;
    v.run_cmd |= (j > 21);
    v.output_voltage |= (j > 21);
    v.dc_braking |= (j == 23);
    v.accelerating |= (j == 24);
    v.exp_card_present |= (j > 24);
    v.exp_cmd_lost |= (j == 26);
    return v;
  endfunction : vec

  function automatic logic expf(input logic [5:0] s, input dsos_pkg::dsos_cond_s c,
                                input logic [2:0] m);
    logic run;
    run = c.run_cmd & c.output_voltage & ~c.dc_braking;
    case (s)
      6'h0B: return c.dc_undervoltage;
      6'h0C: return c.over_temperature;
      6'h0D: return c.analog_ref_lost | c.serial_cmd_lost | (c.exp_card_present & c.exp_cmd_lost);
      6'h0E: return run;
      6'h0F: return ~c.run_cmd & ~c.output_voltage;
      6'h10: return run & ~c.accelerating & ~c.decelerating;
      6'h11: return c.motor_on_drive_line;
      6'h12: return c.motor_on_mains;
      6'h13: return c.speed_search;
      6'h16: return c.standby_ready;
      6'h1D: return |(m & {c.restart_failed, c.trip_other, c.trip_undervoltage});
      6'h1F: return c.brake_resistor_duty_warning;
      6'h23: return c.brake_release_output;
      default: return 1'b0;
    endcase
  endfunction : expf

  // Watchdog against a hang
  initial begin
    repeat (100000) @(posedge core_clk);
    fail_count++;
    give_verdict();
  end

  // Main sequence
  initial begin
    cf = '0;
    cf.relay3_sel = 6'h1D;
    cf.relay4_sel = 6'h1D;
    cf.trip_mask = 3'h2;
    cf.ana_on_level = 12'hFFF;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    wt(1);
    chk("cfg_active", cf, cfg_active);
    chk("outputs", 4'h0, {seen, fos});
    for (int m = 0; m < 2; m++) begin
      cf.trip_mask = m ? 3'h5 : 3'h2;
      foreach (CODES[k]) begin
        cf.term_sel = CODES[k];
        cf.relay3_sel = CODES[k];
        cf.relay4_sel = CODES[k];
        load(cf);
        for (int j = 0; j < 27; j++) begin
          put(vec(j));
          wt(3);
          chk("seen", {3{expf(CODES[k], vec(j), cf.trip_mask)}}, seen);
        end
      end
    end
    // Trip on and off delays, with a restart
    cf.trip_mask = 3'h2;
    cf.fault_output_assert_delay = 14'h0003;
    cf.fault_output_release_delay = 14'h0002;
    load(cf);
    tv = '0;
    tv.trip_other = 1'b1;
    put(tv);
    wt(6);
    chk("fos", 1'b0, fos);
    wt(10);
    chk("fos", 1'b1, fos);
    put('0);
    wt(5);
    chk("fos", 1'b1, fos);
    wt(7);
    chk("fos", 1'b0, fos);
    put(tv);
    wt(6);
    put('0);
    put(tv);
    wt(9);
    chk("fos", 1'b0, fos);
    wt(7);
    chk("fos", 1'b1, fos);
    put('0);
    // Timer started from its input
    cf.relay3_sel = 6'h1C;
    cf.timer_delay = 14'h0002;
    load(cf);
    tv = '0;
    tv.timer_input = 1'b1;
    put(tv);
    wt(3);
    chk("timer", 1'b0, r3_out);
    wt(9);
    chk("timer", 1'b1, r3_out);
    put('0);
    wt(3);
    chk("timer", 1'b0, r3_out);
    // Analog on/off with hysteresis
    cf.relay3_sel = 6'h22;
    cf.ana_on_level = 12'h800;
    cf.ana_off_level = 12'h400;
    load(cf);
    foreach (AV[i]) begin
      @(posedge core_clk);
      analog_value <= AV[i];
      wt(3);
      chk("analog", AE[5 - i], r3_out);
    end
    // Oversized delay is clamped
    cf.fault_output_release_delay = 14'h3FFF;
    load(cf);
    wt(1);
    chk("clamp", 14'h2710, cfg_active.fault_output_release_delay);
    give_verdict();
  end
endmodule : test_drive_status_output_select

bind dsos_top dsos_props #(.TICK_CYCLES(TICK_CYCLES)) dsos_props_i (.core_clk(core_clk),
  .rst_n(rst_n), .cond(cond), .analog_value(analog_value), .cfg_load(cfg_load),
  .cfg_in(cfg_in), .transistor_output_terminal(transistor_output_terminal),
  .relay3_output(relay3_output), .relay4_output(relay4_output),
  .fault_output_state(fault_output_state), .cfg_active(cfg_active));
`default_nettype wire
